/* File: isp_pkg.sv */
package isp_pkg;

  // ------------------------------------------------------------
  // instruction encodings
  // ------------------------------------------------------------
  localparam logic [7:0] UNLOCK_B1 = 8'hac;
  localparam logic [7:0] UNLOCK_B2 = 8'h53;
  localparam logic [2:0] ERASE_B2_TOP = 3'h4;
  localparam logic [3:0] READ_FLASH_HI = 4'h2;
  localparam logic [3:0] LOAD_PAGE_HI = 4'h4;
  localparam logic [2:0] FLASH_OP_LO = 3'h0;
  localparam logic [7:0] COMMIT_B1 = 8'h4c;
  localparam logic [7:0] READ_EE_B1 = 8'ha0;
  localparam logic [7:0] WRITE_EE_B1 = 8'hc0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ------------------------------------------------------------
  // field positions and memory geometry
  // ------------------------------------------------------------
  localparam int PAGE_IDX_W = 5;
  localparam int PAGE_NUM_W = 7;
  localparam int WORD_ADDR_W = PAGE_IDX_W + PAGE_NUM_W;
  localparam int EE_ADDR_W = 9;
  localparam int FLASH_WORDS = 1 << WORD_ADDR_W;
  localparam int PAGE_WORDS = 1 << PAGE_IDX_W;
  localparam int EE_BYTES = 1 << EE_ADDR_W;
  localparam int HI_SEL_BIT = 3;

  // ------------------------------------------------------------
  // self-timed write waits
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FLASH_WRITE_WAIT_US = 4500;
  localparam int EEPROM_WRITE_WAIT_US = 9000;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FLASH_WRITE_WAIT_CYC = FLASH_WRITE_WAIT_US * CLK_MHZ;
  localparam int EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } frame_t;

  typedef enum logic [1:0] {WOP_COMMIT, WOP_EEPROM, WOP_ERASE} wr_kind_t;

  typedef struct packed {
    wr_kind_t kind;
    logic [WORD_ADDR_W-1:0] addr;
    logic [7:0] data;
  } wr_op_t;

  typedef enum {W_IDLE, W_WAIT} wr_state_t;

endpackage

/* File: isp_fifo2.sv */
`timescale 1ns/1ps
module isp_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0] count_r, count_nxt;
  logic push, pop;

  // ------------------------------------------------------------
  // pointers and fill level
  // ------------------------------------------------------------
  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // full and empty come from one count, so they can never disagree
  always_comb begin
    wr_ptr_nxt = wr_ptr_r + PW'(push);
    rd_ptr_nxt = rd_ptr_r + PW'(pop);
    count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage carries no reset; a slot is only read after it is written
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule

/* File: isp_serial_prog.sv */
`timescale 1ns/1ps
// Function
// [R01] programming over serial pins only while the device reset pin is low
// [R02] program and erase ignored until the unlock instruction has run
// [R03] eeprom write erases its location inside the self-timed cycle
// [R04] chip erase sets all flash and eeprom locations to 0xff
// [R05] programmer keeps sck phases longer than two or three cpu clocks
// [R06] mosi is sampled on rising sck
// [R07] miso changes on falling sck
// [R08] programmer holds reset and sck low at power-up, else pulses reset
// [R09] programmer waits 20 ms before sending the unlock instruction; the programmer model waits 100 clocks
// [R10] in sync, 0x53 echoes back while the third unlock byte shifts in
// [R11] programmer sends all four bytes, resyncs by reset pulse on bad echo; the testbench checks the echo but never resyncs
// [R12] page loaded bytewise by five low word-address bits, low byte first
// [R13] page commit with seven high address bits stores the page buffer
// [R14] without polling, programmer waits 4.5 ms after a page commit
// [R15] eeprom written bytewise; without polling programmer waits 9.0 ms
// [R16] during any write only polling reads may be issued; the design queues up to two further writes meanwhile
// [R17] read instructions return the selected location on miso
// [R18] reads inside a flash page being written return 0xff
// [R19] polling cannot see 0xff data; programmer then waits full delay
// [R20] read of an eeprom byte being written returns 0xff until done
// [R21] releasing reset high leaves programming mode
// [R22] unlock is 0xac 0x53 then two don't-care bytes
// [R23] chip erase is 0xac then a byte with top bits 100
// [R24] page commit is 0x4c then high and low page address bits
// [R25] eeprom write is 0xc0, address in bytes two and three, data fourth
// [R26] bytes shift msb first, one response byte per byte received
module isp_serial_prog import isp_pkg::*; #(
  parameter int FLASH_WAIT_CYC = FLASH_WRITE_WAIT_CYC,
  parameter int EEPROM_WAIT_CYC = EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_CYC = ERASE_WAIT_CYC,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic prog_reset_n_pin,
  input wire logic sck_pin,
  input wire logic mosi_pin,
  output logic miso,
  output logic prog_active,
  output logic unlocked,
  output logic busy
);

  if (FLASH_WAIT_CYC < 1 || EEPROM_WAIT_CYC < 1 || ERASE_CYC < 1) begin : g_bad_wait
    $error("write wait counts must be at least one cycle");
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r, sck_sync_r, mosi_sync_r;
  logic sck_d_r, prog_active_r;
  logic sck_rise, sck_fall;

  // stage [0] feeds only stage [1]; edges are found past the second stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h3;
      sck_sync_r <= 2'h0;
      mosi_sync_r <= 2'h0;
      sck_d_r <= 1'b0;
      prog_active_r <= 1'b0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], prog_reset_n_pin};
      sck_sync_r <= {sck_sync_r[0], sck_pin};
      mosi_sync_r <= {mosi_sync_r[0], mosi_pin};
      sck_d_r <= sck_sync_r[1];
      prog_active_r <= ~rst_sync_r[1]; // R01 R21
    end
  end

  // each sck phase spans several clocks, so no edge is missed R05
  assign sck_rise = prog_active_r & sck_sync_r[1] & ~sck_d_r;
  assign sck_fall = prog_active_r & ~sck_sync_r[1] & sck_d_r;

  // ------------------------------------------------------------
  // writer state and memories (declared ahead of the read path)
  // ------------------------------------------------------------
  wr_state_t state_r, state_nxt;
  wr_op_t cur_r, cur_nxt, push_op, pop_op;
  logic [31:0] wait_cnt_r, wait_cnt_nxt;
  logic busy_r, w_done, push_valid, push_ready, pop_valid, pop_ready;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] page_buf [PAGE_WORDS];

  function automatic logic [31:0] wait_limit(input wr_kind_t k);
    case (k)
      WOP_COMMIT: wait_limit = 32'(FLASH_WAIT_CYC);
      WOP_EEPROM: wait_limit = 32'(EEPROM_WAIT_CYC);
      default: wait_limit = 32'(ERASE_CYC);
    endcase
  endfunction

  function automatic logic [EE_ADDR_W-1:0] ee_addr(input logic [7:0] hi, input logic [7:0] lo);
    ee_addr = {hi[0], lo};
  endfunction

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [7:0] rx_in, rd_data, rx_sh_r, rx_sh_nxt;
  logic [WORD_ADDR_W-1:0] rd_word;
  logic [EE_ADDR_W-1:0] rd_ee_addr;
  logic [15:0] rd_fword;
  logic rd_flash, rd_ee, rd_hit, page_busy, ee_busy;
  frame_t frame_r, frame_nxt;

  // byte three arrives on the edge that completes it, so the address uses rx_in
  assign rx_in = {rx_sh_r[6:0], mosi_sync_r[1]};
  assign rd_flash = frame_r.b1[7:4] == READ_FLASH_HI && frame_r.b1[2:0] == FLASH_OP_LO;
  assign rd_ee = frame_r.b1 == READ_EE_B1;
  assign rd_hit = rd_flash | rd_ee;
  assign rd_word = {frame_r.b2[3:0], rx_in};
  assign rd_ee_addr = ee_addr(frame_r.b2, rx_in);
  assign rd_fword = flash_mem[rd_word];
  assign page_busy = busy_r && (cur_r.kind == WOP_ERASE ||
    (cur_r.kind == WOP_COMMIT && rd_word[WORD_ADDR_W-1:PAGE_IDX_W] == cur_r.addr[PAGE_NUM_W-1:0]));
  assign ee_busy = busy_r && (cur_r.kind == WOP_ERASE ||
    (cur_r.kind == WOP_EEPROM && rd_ee_addr == cur_r.addr[EE_ADDR_W-1:0]));

  // a location still being written reads erased, which is what polling watches
  always_comb begin
    rd_data = ERASED_BYTE;
    if (rd_flash && !page_busy) begin // R18
      rd_data = frame_r.b1[HI_SEL_BIT] ? rd_fword[15:8] : rd_fword[7:0]; // R17
    end else if (rd_ee && !ee_busy) begin // R20 R03
      rd_data = ee_mem[rd_ee_addr]; // R17
    end
  end

  // ------------------------------------------------------------
  // serial link: shift, frame, respond
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_idx_r, byte_idx_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic miso_r, miso_nxt, unlocked_r, unlocked_nxt;
  logic byte_done, frame_done, page_we, is_unlock;
  frame_t fdone;

  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    byte_idx_nxt = byte_idx_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    miso_nxt = miso_r;
    frame_nxt = frame_r;
    unlocked_nxt = unlocked_r;
    byte_done = 1'b0;
    frame_done = 1'b0;
    fdone = frame_r;
    fdone.b4 = rx_in;
    if (!prog_active_r) begin
      // leaving programming mode drops the lock and any partial frame R01 R21 R11
      bit_cnt_nxt = '0;
      byte_idx_nxt = '0;
      rx_sh_nxt = '0;
      tx_sh_nxt = '0;
      miso_nxt = 1'b0;
      unlocked_nxt = 1'b0;
    end else if (sck_rise) begin
      rx_sh_nxt = rx_in; // R06 R26
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        byte_done = 1'b1;
        byte_idx_nxt = byte_idx_r + 2'h1;
        case (byte_idx_r)
          2'h0: frame_nxt.b1 = rx_in;
          2'h1: frame_nxt.b2 = rx_in;
          2'h2: frame_nxt.b3 = rx_in;
          default: begin
            frame_nxt.b4 = rx_in;
            frame_done = 1'b1; // R26
          end
        endcase
        // each byte echoes back during the next; reads answer in byte four R10 R26
        tx_sh_nxt = (byte_idx_r == 2'h2 && rd_hit) ? rd_data : rx_in; // R17
        if (frame_done && is_unlock) begin
          unlocked_nxt = 1'b1; // R02 R22
        end
      end
    end else if (sck_fall) begin
      miso_nxt = tx_sh_r[7]; // R07 R26
      tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
    end
  end

  assign is_unlock = fdone.b1 == UNLOCK_B1 && fdone.b2 == UNLOCK_B2;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r <= '0;
      byte_idx_r <= '0;
      rx_sh_r <= '0;
      tx_sh_r <= '0;
      miso_r <= 1'b0;
      frame_r <= '0;
      unlocked_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      miso_r <= miso_nxt;
      frame_r <= frame_nxt;
      unlocked_r <= unlocked_nxt;
    end
  end

  // ------------------------------------------------------------
  // instruction decode into page loads and queued writes
  // ------------------------------------------------------------
  // a write that finds the queue full is dropped; only polling is legal then R16
  always_comb begin
    page_we = 1'b0;
    push_valid = 1'b0;
    push_op = '0;
    push_op.data = fdone.b4;
    if (frame_done && unlocked_r) begin // R02
      if (fdone.b1[7:4] == LOAD_PAGE_HI && fdone.b1[2:0] == FLASH_OP_LO) begin
        page_we = 1'b1; // R12
      end else if (fdone.b1 == COMMIT_B1) begin
        push_valid = 1'b1; // R13 R24
        push_op.kind = WOP_COMMIT;
        push_op.addr = WORD_ADDR_W'({fdone.b2[3:0], fdone.b3[7:5]});
      end else if (fdone.b1 == WRITE_EE_B1) begin
        push_valid = 1'b1; // R15 R25
        push_op.kind = WOP_EEPROM;
        push_op.addr = WORD_ADDR_W'(ee_addr(fdone.b2, fdone.b3));
      end else if (fdone.b1 == UNLOCK_B1 && fdone.b2[7:5] == ERASE_B2_TOP) begin
        push_valid = 1'b1; // R23
        push_op.kind = WOP_ERASE;
      end
    end
  end

  isp_fifo2 #(
    .WIDTH($bits(wr_op_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_queue (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_op),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_op)
  );

  // ------------------------------------------------------------
  // self-timed writer
  // ------------------------------------------------------------
  // the writer stalls the queue for the whole wait, so commands back up there
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    wait_cnt_nxt = wait_cnt_r;
    pop_ready = 1'b0;
    w_done = 1'b0;
    case (state_r)
      W_IDLE: begin
        pop_ready = 1'b1;
        if (pop_valid) begin
          cur_nxt = pop_op;
          wait_cnt_nxt = '0;
          state_nxt = W_WAIT;
        end
      end
      W_WAIT: begin
        if (wait_cnt_r == wait_limit(cur_r.kind) - 32'h1) begin
          w_done = 1'b1; // R14 R15
          state_nxt = W_IDLE;
        end else begin
          wait_cnt_nxt = wait_cnt_r + 32'h1;
        end
      end
      default: state_nxt = W_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= W_IDLE;
      cur_r <= '0;
      wait_cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      busy_r <= (state_nxt == W_WAIT);
    end
  end

  // arrays land only at the end of the wait; the read path masks them meanwhile
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < FLASH_WORDS; i++) flash_mem[i] <= ERASED_WORD;
      for (int i = 0; i < EE_BYTES; i++) ee_mem[i] <= ERASED_BYTE;
      for (int i = 0; i < PAGE_WORDS; i++) page_buf[i] <= ERASED_WORD;
    end else begin
      if (page_we && fdone.b1[HI_SEL_BIT]) begin
        page_buf[fdone.b3[PAGE_IDX_W-1:0]][15:8] <= fdone.b4; // R12
      end else if (page_we) begin
        page_buf[fdone.b3[PAGE_IDX_W-1:0]][7:0] <= fdone.b4; // R12
      end
      if (w_done && cur_r.kind == WOP_COMMIT) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
          flash_mem[{cur_r.addr[PAGE_NUM_W-1:0], PAGE_IDX_W'(i)}] <= page_buf[i]; // R13
        end
      end else if (w_done && cur_r.kind == WOP_EEPROM) begin
        ee_mem[cur_r.addr[EE_ADDR_W-1:0]] <= cur_r.data; // R03
      end else if (w_done) begin
        for (int i = 0; i < FLASH_WORDS; i++) flash_mem[i] <= ERASED_WORD; // R04
        for (int i = 0; i < EE_BYTES; i++) ee_mem[i] <= ERASED_BYTE; // R04
      end
    end
  end

  assign miso = miso_r;
  assign prog_active = prog_active_r;
  assign unlocked = unlocked_r;
  assign busy = busy_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_prog_gate;
    !prog_active_r |=> !unlocked_r && byte_idx_r == 2'h0;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("link state kept outside programming mode"); // R01

  property p_locked_no_write;
    (push_valid || page_we) |-> unlocked_r;
  endproperty
  a_locked_no_write: assert property (p_locked_no_write) else $error("write accepted while locked"); // R02

  property p_mosi_rise;
    sck_rise |=> rx_sh_r[0] == $past(mosi_sync_r[1]) && rx_sh_r[7:1] == $past(rx_sh_r[6:0]);
  endproperty
  a_mosi_rise: assert property (p_mosi_rise) else $error("mosi not shifted in msb first"); // R06

  property p_miso_fall;
    (miso_r != $past(miso_r)) |-> $past(sck_fall) || !$past(prog_active_r);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved away from falling sck"); // R07

  property p_unlock_echo;
    (byte_done && byte_idx_r == 2'h1 && frame_r.b1 == UNLOCK_B1 && rx_in == UNLOCK_B2) |=> tx_sh_r == UNLOCK_B2;
  endproperty
  a_unlock_echo: assert property (p_unlock_echo) else $error("unlock echo not loaded"); // R10

  property p_wait_len;
    w_done |-> wait_cnt_r == wait_limit(cur_r.kind) - 32'h1 && state_r == W_WAIT;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("write finished with wrong wait"); // R14

  property p_erase_all;
    (w_done && cur_r.kind == WOP_ERASE) |=> flash_mem[0] == ERASED_WORD && ee_mem[0] == ERASED_BYTE;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("chip erase left data"); // R04

  property p_ee_poll;
    (busy_r && rd_ee && ee_busy) |-> rd_data == ERASED_BYTE;
  endproperty
  a_ee_poll: assert property (p_ee_poll) else $error("eeprom poll read not erased"); // R20

  property p_page_poll;
    (busy_r && rd_flash && page_busy) |-> rd_data == ERASED_BYTE;
  endproperty
  a_page_poll: assert property (p_page_poll) else $error("page poll read not erased"); // R18

  // the finished op stays in cur_r for one more cycle, until the writer pops again
  property p_ee_store;
    (w_done && cur_r.kind == WOP_EEPROM) |=> ee_mem[cur_r.addr[EE_ADDR_W-1:0]] == cur_r.data;
  endproperty
  a_ee_store: assert property (p_ee_store) else $error("eeprom byte not stored"); // R15

  c_unlock: cover property (frame_done && is_unlock);
  c_commit: cover property (w_done && cur_r.kind == WOP_COMMIT);
  c_eeprom: cover property (w_done && cur_r.kind == WOP_EEPROM);
  c_erase: cover property (w_done && cur_r.kind == WOP_ERASE);
  c_queued: cover property (push_valid && push_ready && busy_r);

endmodule

/* File: isp_programmer.sv */
`timescale 1ns/1ps
// ----------------------------------------------
// programmer model: spi mode 0 master on the pins
// ----------------------------------------------
module isp_programmer (
  input wire logic clock,
  output logic prog_reset_n_pin,
  output logic sck_pin,
  output logic mosi_pin,
  input wire logic miso
);
  localparam int HALF = 20;

  // power up with reset released and sck parked low
  initial begin
    prog_reset_n_pin = 1'b1;
    sck_pin = 1'b0;
    mosi_pin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // reset pulse only once sck is low; settle wait is scaled down
  task automatic enter();
    @(posedge clock);
    sck_pin <= 1'b0;
    prog_reset_n_pin <= 1'b1;
    tick(4);
    prog_reset_n_pin <= 1'b0;
    tick(100);
  endtask

  task automatic leave();
    @(posedge clock);
    prog_reset_n_pin <= 1'b1;
    tick(6);
  endtask

  // all 32 bits always go out; miso taken just before each rising sck
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clock);
      mosi_pin <= tx[i];
      tick(HALF);
      rx[i] = miso;
      sck_pin <= 1'b1;
      tick(HALF);
      sck_pin <= 1'b0;
    end
    // data is not held after the frame, so flip it rather than leave it
    @(posedge clock);
    mosi_pin <= ~mosi_pin;
  endtask
endmodule

/* File: serial_flash_eeprom_programming_tb.sv */
`timescale 1ns/1ps
module serial_flash_eeprom_programming_tb;
  import isp_pkg::*;
  logic clock, reset_n, prog_reset_n_pin, sck, mosi, miso, prog_active, unlocked, busy;
  logic [31:0] seed = 32'h9a8318ec;
  logic [31:0] rx;
  logic [7:0] ee_m[int];
  logic [7:0] fl_m[int];
  logic [7:0] pb_m[int];
  logic unl = 1'b0;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int ea, pg, w;
  logic [7:0] d;

  // --------------------------------------------
  // design, programmer model, clock and watchdog
  // --------------------------------------------
  // waits shortened but longer than a frame, so polling can see them
  isp_serial_prog #(.FLASH_WAIT_CYC(2500), .EEPROM_WAIT_CYC(3000), .ERASE_CYC(3500)) DUT (
    .clock(clock), .reset_n(reset_n), .prog_reset_n_pin(prog_reset_n_pin), .sck_pin(sck),
    .mosi_pin(mosi), .miso(miso), .prog_active(prog_active), .unlocked(unlocked), .busy(busy));
  isp_programmer prog (.clock(clock), .prog_reset_n_pin(prog_reset_n_pin), .sck_pin(sck),
    .mosi_pin(mosi), .miso(miso));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ceiling about twice what the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fails++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction

  function automatic logic [7:0] ee_exp(input int a);
    return ee_m.exists(a) ? ee_m[a] : ERASED_BYTE;
  endfunction

  function automatic logic [7:0] fl_exp(input int k);
    return fl_m.exists(k) ? fl_m[k] : ERASED_BYTE;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, wanted %h", $time, seen, exp);
    end
  endtask

  // --------------------------------------------
  // instruction helpers, model updated alongside
  // --------------------------------------------
  task automatic ee_wr(input logic [8:0] a, input logic [7:0] dv);
    prog.frame({WRITE_EE_B1, 7'h0, a, dv}, rx);
    if (unl) ee_m[a] = dv;
  endtask

  task automatic ee_rd(input logic [8:0] a, input logic [7:0] e);
    prog.frame({READ_EE_B1, 7'h0, a, 8'h00}, rx);
    chk(rx[7:0], e);
  endtask

  task automatic fl_ld(input logic [11:0] wa, input logic h, input logic [7:0] dv);
    prog.frame({LOAD_PAGE_HI, h, FLASH_OP_LO, 8'h00, 3'h0, wa[4:0], dv}, rx);
    pb_m[{wa[4:0], h}] = dv;
  endtask

  task automatic fl_rd(input logic [11:0] wa, input logic h, input logic [7:0] e);
    prog.frame({READ_FLASH_HI, h, FLASH_OP_LO, 4'h0, wa[11:8], wa[7:0], 8'h00}, rx);
    chk(rx[7:0], e);
  endtask

  task automatic wait_idle();
    int q;
    q = 0;
    for (int n = 0; n < 20000 && q < 8; n++) begin
      @(posedge clock);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    chk(q, 8);
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    reset_n = 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    prog.enter();
    chk(prog_active, 1'b1);
    ea = rnd() & 32'h1fe;
    d = 8'(rnd());
    ee_wr(9'(ea), d);
    prog.tick(4);
    chk(busy, 1'b0);
    ee_rd(9'(ea), ERASED_BYTE);
    prog.frame({UNLOCK_B1, UNLOCK_B2, 16'(rnd())}, rx);
    chk(rx[23:16], UNLOCK_B1);
    chk(rx[15:8], UNLOCK_B2);
    prog.tick(2);
    chk(unlocked, 1'b1);
    unl = 1'b1;
    // back to back writes: the second parks in the buffer behind the first
    ee_wr(9'(ea), d);
    ee_wr(9'(ea + 1), ~d);
    ee_rd(9'(ea), ERASED_BYTE);
    wait_idle();
    ee_rd(9'(ea), ee_exp(ea));
    ee_rd(9'(ea + 1), ee_exp(ea + 1));
    ee_wr(9'(ea), 8'(rnd()));
    wait_idle();
    ee_rd(9'(ea), ee_exp(ea));
    pg = rnd() & 32'h7f;
    w = rnd() & 32'h1e;
    for (int k = 0; k < 4; k++) begin
      fl_ld({7'(pg), 5'(w + k / 2)}, 1'(k % 2), 8'(rnd()));
    end
    prog.frame({COMMIT_B1, 4'h0, 4'(pg >> 3), 3'(pg), 5'h0, 8'h00}, rx);
    foreach (pb_m[k]) fl_m[{7'(pg), 6'(k)}] = pb_m[k];
    prog.tick(4);
    chk(busy, 1'b1);
    fl_rd({7'(pg), 5'(w)}, 1'b0, ERASED_BYTE);
    wait_idle();
    for (int k = 0; k < 4; k++) begin
      fl_rd({7'(pg), 5'(w + k / 2)}, 1'(k % 2), fl_exp({7'(pg), 5'(w + k / 2), 1'(k % 2)}));
    end
    prog.frame({UNLOCK_B1, ERASE_B2_TOP, 5'h0, 16'h0}, rx);
    ee_m.delete();
    fl_m.delete();
    wait_idle();
    ee_rd(9'(ea + 1), ee_exp(ea + 1));
    fl_rd({7'(pg), 5'(w)}, 1'b1, fl_exp({7'(pg), 5'(w), 1'b1}));
    // reset in mid-write: the write is lost, the lock drops and the arrays read erased
    ee_wr(9'(ea), 8'(rnd()));
    prog.tick(4);
    chk(busy, 1'b1);
    reset_n <= 1'b0;
    prog.tick(2);
    chk(busy, 1'b0);
    chk(unlocked, 1'b0);
    reset_n <= 1'b1;
    ee_m.delete();
    prog.enter();
    ee_rd(9'(ea), ee_exp(ea));
    prog.leave();
    chk(prog_active, 1'b0);
    chk(unlocked, 1'b0);
    end_sim();
  end
endmodule
